// *** qsdsp_pkg.sv ***
// Constants and types for the quad sigma-delta decimator and serial port
// Operation
// R1 - Ready falls when a new word is available
// R2 - Ready returns high after four 32-bit words
// R3 - Ready high one master cycle during reload
// R4 - Host must not read during reload pulse
// R5 - Control writes accepted only inside write frame
// R6 - Auxiliary input bit carried in every word
// R7 - Two general outputs follow control register bits
// R8 - Modulators sample at master clock over 14
// R9 - Five binary cutoff settings, 584 to 36.5 Hz
// R10 - Update rate set by clock and cutoff
// R11 - Channels sampled continuously, no start command
// R12 - Update rate at most 2.2 kHz
// R13 - Settling scales with clock period and cutoff
// R14 - Decimation filter has linear phase
// R15 - Reset pulse resyncs sampling and interface
// R16 - Mode input selects master or slave pin directions
// R17 - Chain enable gates stream, done after burst
// R18 - Word holds result, channel, address, aux bit
// R19 - Channel words sent in ascending order
package qsdsp_pkg;

	localparam int SYS_CLK_HZ     = 50_000_000;
	localparam int MCLK_MAX_HZ    = 8_000_000;
	localparam int MCLK_DIV       = (SYS_CLK_HZ + MCLK_MAX_HZ - 1) / MCLK_MAX_HZ;
	localparam int LD_W           = $clog2(MCLK_DIV);
	localparam logic [LD_W-1:0] MCLK_LAST = LD_W'(MCLK_DIV - 1);

	localparam int MOD_DIV        = 14;
	localparam int MOD_W          = 4;
	localparam logic [MOD_W-1:0] MOD_LAST = MOD_W'(MOD_DIV - 1);

	localparam int DEC_BASE_LOG2  = 8;
	localparam int FC_SETTINGS    = 5;
	localparam logic [2:0] FC_MAX = 3'(FC_SETTINGS - 1);
	localparam int DEC_W          = DEC_BASE_LOG2 + FC_SETTINGS - 1;

	localparam int CHAN_COUNT     = 4;
	localparam logic [1:0] CHAN_LAST = 2'(CHAN_COUNT - 1);
	localparam int RESULT_W       = 22;
	localparam int ACC_W          = 40;
	localparam int SCALE_BASE     = 3 * DEC_BASE_LOG2 + 1 - RESULT_W;
	localparam logic signed [ACC_W-1:0] RES_MAX = ACC_W'((64'sd1 <<< (RESULT_W - 1)) - 1);
	localparam logic signed [ACC_W-1:0] RES_MIN = -(RES_MAX + ACC_W'(1));
	localparam logic signed [ACC_W-1:0] ACC_ONE = ACC_W'(1);

	localparam int WORD_W         = 32;
	localparam logic [4:0] WORD_LAST = 5'(WORD_W - 1);
	localparam int RES_LSB        = 10;
	localparam int CHAN_LSB       = 8;
	localparam int ADDR_LSB       = 5;
	localparam int AUX_BIT        = 4;
	localparam int PAD_W          = 4;
	localparam int FIFO_WORDS     = 16;

	localparam int CTRL_W         = 8;
	localparam int CCNT_W         = $clog2(CTRL_W + 1);
	localparam logic [CCNT_W-1:0] CTRL_FULL = CCNT_W'(CTRL_W);
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
	localparam int CTRL_FC_LSB    = 0;
	localparam int CTRL_GPA_BIT   = 3;
	localparam int CTRL_GPB_BIT   = 4;

	localparam int SCLK_HALF      = 2;
	localparam int SCLK_W         = 1;
	localparam logic [SCLK_W-1:0] SCLK_HALF_LAST = SCLK_W'(SCLK_HALF - 1);

	localparam int SYNC_W         = 15;

	typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SHIFT} qsdsp_tx_e;

endpackage

// *** qsdsp_fifo.sv ***
// Word FIFO between the decimator output packer and the serial port
`timescale 1ns/1ps
module qsdsp_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             clear_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in,
	output logic [WIDTH-1:0]      out_data_out
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("FIFO depth must be a power of two");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;
	logic             push;
	logic             pop;

	assign out_valid_out = (wr_q != rd_q);
	assign in_ready_out  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
	assign out_data_out  = mem_q[rd_q[AW-1:0]];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else if (clear_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data_in;
		end
	end
endmodule

// *** qsdsp_top.sv ***
// Quad sigma-delta decimation filters, word packer and serial port
`timescale 1ns/1ps
module qsdsp_top
	import qsdsp_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_WORDS
) (
	input  wire logic       clk_sys_in,
	input  wire logic       nrst_in,
	input  wire logic       reset_pulse_in,
	input  wire logic       mode_slave_in,
	input  wire logic       chain_enable_in,
	input  wire logic       aux_flag_in,
	input  wire logic [2:0] device_addr_pins_in,
	input  wire logic [3:0] mod_bit_in,
	input  wire logic       ctrl_write_frame_n_in,
	input  wire logic       rx_frame_sync_in,
	output logic            rx_frame_sync_out,
	output logic            rx_frame_sync_oe_out,
	input  wire logic       sclk_in,
	output logic            sclk_out,
	output logic            sclk_oe_out,
	input  wire logic       serial_io_in,
	output logic            serial_io_out,
	output logic            serial_io_oe_out,
	output logic            word_ready_n_out,
	output logic            chain_done_out,
	output logic            gp_out_a_out,
	output logic            gp_out_b_out,
	output logic [2:0]      cutoff_sel_out
);
	if (FIFO_DEPTH < CHAN_COUNT || FIFO_DEPTH % CHAN_COUNT != 0) begin : g_bad_fifo
		$error("FIFO depth must hold whole four-word bursts");
	end

	// Decimation ratio minus one for a cutoff setting
	function automatic logic [DEC_W-1:0] dec_last(input logic [2:0] fc);
		dec_last = DEC_W'((1 << (DEC_BASE_LOG2 + int'(fc))) - 1);
	endfunction

	// Scale a third-order comb output to a saturated signed result
	function automatic logic [RESULT_W-1:0] scale_result(input logic signed [ACC_W-1:0] v,
			input logic [2:0] fc);
		logic signed [ACC_W-1:0] s;
		s = v >>> (SCALE_BASE + 3 * int'(fc));
		if (s > RES_MAX) begin
			s = RES_MAX;
		end else if (s < RES_MIN) begin
			s = RES_MIN;
		end
		scale_result = s[RESULT_W-1:0];
	endfunction

	logic                    rst_n_m_q;
	logic                    rst_n_q;
	logic [SYNC_W-1:0]       sync1_q;
	logic [SYNC_W-1:0]       sync2_q;
	logic [SYNC_W-1:0]       async_in;
	logic [3:0]              mod_s;
	logic [2:0]              addr_s;
	logic                    sdi_s;
	logic                    sclk_s;
	logic                    rfs_s;
	logic                    tfs_n_s;
	logic                    aux_s;
	logic                    chain_s;
	logic                    slave_s;
	logic                    clr_s;
	logic                    sclk_d_q;
	logic                    master_q;
	logic [LD_W-1:0]         mclk_cnt_q;
	logic [MOD_W-1:0]        samp_cnt_q;
	logic [DEC_W-1:0]        dec_cnt_q;
	logic                    mclk_en;
	logic                    samp_en;
	logic                    dec_en;
	logic [2:0]              fc_eff;
	logic [2:0]              fc_q;
	logic                    filt_rst;
	logic signed [ACC_W-1:0] int1_q [CHAN_COUNT];
	logic signed [ACC_W-1:0] int2_q [CHAN_COUNT];
	logic signed [ACC_W-1:0] int3_q [CHAN_COUNT];
	logic signed [ACC_W-1:0] dly1_q [CHAN_COUNT];
	logic signed [ACC_W-1:0] dly2_q [CHAN_COUNT];
	logic signed [ACC_W-1:0] dly3_q [CHAN_COUNT];
	logic signed [ACC_W-1:0] cmb1 [CHAN_COUNT];
	logic signed [ACC_W-1:0] cmb2 [CHAN_COUNT];
	logic signed [ACC_W-1:0] cmb3 [CHAN_COUNT];
	logic [RESULT_W-1:0]     res_q [CHAN_COUNT];
	logic                    pack_busy_q;
	logic [1:0]              pack_idx_q;
	logic                    fifo_in_ready;
	logic [WORD_W-1:0]       fifo_in_data;
	logic                    fifo_out_valid;
	logic                    fifo_out_ready;
	logic [WORD_W-1:0]       fifo_out_data;
	qsdsp_tx_e               st_q;
	logic [LD_W-1:0]         ld_cnt_q;
	logic [4:0]              bit_cnt_q;
	logic [1:0]              burst_q;
	logic [WORD_W-1:0]       shreg_q;
	logic                    word_ready_n_q;
	logic                    chain_done_q;
	logic                    sdo_oe_q;
	logic                    rfs_out_q;
	logic [SCLK_W-1:0]       sdiv_q;
	logic                    sclk_q;
	logic                    gen_run;
	logic                    gen_tick;
	logic                    rise;
	logic                    fall;
	logic                    cap;
	logic                    tx_go;
	logic                    tx_rise;
	logic                    tx_fall;
	logic                    frame_on;
	logic                    frame_act_q;
	logic [CTRL_W-1:0]       ctrl_shift_q;
	logic [CCNT_W-1:0]       ccnt_q;
	logic [CTRL_W-1:0]       ctrl_q;

	// Reset release and pin synchronisers
	always_ff @(posedge clk_sys_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_n_m_q <= 1'b0;
			rst_n_q   <= 1'b0;
		end else begin
			rst_n_m_q <= 1'b1;
			rst_n_q   <= rst_n_m_q;
		end
	end

	assign async_in = {mod_bit_in, device_addr_pins_in, serial_io_in, sclk_in, rx_frame_sync_in,
		ctrl_write_frame_n_in, aux_flag_in, chain_enable_in, mode_slave_in, reset_pulse_in};
	assign {mod_s, addr_s, sdi_s, sclk_s, rfs_s, tfs_n_s, aux_s, chain_s, slave_s, clr_s} = sync2_q;

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync1_q  <= '0;
			sync2_q  <= '0;
			sclk_d_q <= 1'b0;
			master_q <= 1'b0;
		end else begin
			sync1_q  <= async_in;
			sync2_q  <= sync1_q;
			sclk_d_q <= sclk_s;
			master_q <= !slave_s; // R16
		end
	end

	// Master clock, modulator sample and decimation timing
	assign fc_eff   = (ctrl_q[CTRL_FC_LSB +: 3] > FC_MAX) ? FC_MAX : ctrl_q[CTRL_FC_LSB +: 3]; // R9
	assign filt_rst = clr_s || (fc_q != fc_eff); // R15
	assign mclk_en  = (mclk_cnt_q == MCLK_LAST); // R12
	assign samp_en  = mclk_en && (samp_cnt_q == MOD_LAST); // R8
	assign dec_en   = samp_en && (dec_cnt_q == dec_last(fc_q)); // R10 R13

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fc_q       <= CTRL_RESET[CTRL_FC_LSB +: 3];
			mclk_cnt_q <= '0;
			samp_cnt_q <= '0;
			dec_cnt_q  <= '0;
		end else if (filt_rst) begin
			fc_q       <= fc_eff;
			mclk_cnt_q <= '0;
			samp_cnt_q <= '0;
			dec_cnt_q  <= '0;
		end else begin
			mclk_cnt_q <= mclk_en ? '0 : mclk_cnt_q + 1'b1; // R11
			if (mclk_en) begin
				samp_cnt_q <= (samp_cnt_q == MOD_LAST) ? '0 : samp_cnt_q + 1'b1;
			end
			if (samp_en) begin
				dec_cnt_q <= dec_en ? '0 : dec_cnt_q + 1'b1;
			end
		end
	end

	// Third-order sinc decimators, symmetric response
	always_comb begin
		for (int ch = 0; ch < CHAN_COUNT; ch++) begin
			cmb1[ch] = int3_q[ch] - dly1_q[ch]; // R14
			cmb2[ch] = cmb1[ch] - dly2_q[ch];
			cmb3[ch] = cmb2[ch] - dly3_q[ch];
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			for (int ch = 0; ch < CHAN_COUNT; ch++) begin
				int1_q[ch] <= '0;
				int2_q[ch] <= '0;
				int3_q[ch] <= '0;
				dly1_q[ch] <= '0;
				dly2_q[ch] <= '0;
				dly3_q[ch] <= '0;
			end
		end else if (filt_rst) begin
			for (int ch = 0; ch < CHAN_COUNT; ch++) begin
				int1_q[ch] <= '0;
				int2_q[ch] <= '0;
				int3_q[ch] <= '0;
				dly1_q[ch] <= '0;
				dly2_q[ch] <= '0;
				dly3_q[ch] <= '0;
			end
		end else if (samp_en) begin
			for (int ch = 0; ch < CHAN_COUNT; ch++) begin
				int1_q[ch] <= int1_q[ch] + (mod_s[ch] ? ACC_ONE : -ACC_ONE); // R11
				int2_q[ch] <= int2_q[ch] + int1_q[ch];
				int3_q[ch] <= int3_q[ch] + int2_q[ch];
				if (dec_en) begin
					dly1_q[ch] <= int3_q[ch];
					dly2_q[ch] <= cmb1[ch];
					dly3_q[ch] <= cmb2[ch];
				end
			end
		end
	end

	// Word packer, channels pushed in ascending order
	assign fifo_in_data = {res_q[pack_idx_q], pack_idx_q, addr_s, aux_s, {PAD_W{1'b0}}}; // R18 R6

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pack_busy_q <= 1'b0;
			pack_idx_q  <= '0;
			for (int ch = 0; ch < CHAN_COUNT; ch++) begin
				res_q[ch] <= '0;
			end
		end else if (clr_s) begin
			pack_busy_q <= 1'b0;
			pack_idx_q  <= '0;
		end else if (dec_en && !pack_busy_q) begin
			for (int ch = 0; ch < CHAN_COUNT; ch++) begin
				res_q[ch] <= scale_result(cmb3[ch], fc_q);
			end
			pack_busy_q <= 1'b1;
			pack_idx_q  <= '0;
		end else if (pack_busy_q && fifo_in_ready) begin
			pack_busy_q <= (pack_idx_q != CHAN_LAST);
			pack_idx_q  <= pack_idx_q + 1'b1; // R19
		end
	end

	qsdsp_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_in        (clk_sys_in),
		.rst_n_in      (rst_n_q),
		.clear_in      (clr_s),
		.in_valid_in   (pack_busy_q),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (fifo_in_data),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_data)
	);

	// Serial clock: generated in master mode, sampled pin in slave mode
	assign frame_on = !tfs_n_s;
	assign tx_go    = (st_q == TX_SHIFT) && chain_s; // R17
	assign gen_run  = master_q && (tx_go || frame_act_q);
	assign gen_tick = gen_run && (sdiv_q == SCLK_HALF_LAST);
	assign rise     = master_q ? (gen_tick && !sclk_q) : (sclk_s && !sclk_d_q);
	assign fall     = master_q ? (gen_tick && sclk_q) : (!sclk_s && sclk_d_q);
	// Master: data line is two cycles late, so the line at the rise shows at the fall
	assign cap      = master_q ? fall : rise; // R5
	assign tx_rise  = rise && tx_go && (master_q || rfs_s);
	assign tx_fall  = fall && tx_go && (master_q || rfs_s);

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sdiv_q <= '0;
			sclk_q <= 1'b0;
		end else if (!gen_run || clr_s) begin
			sdiv_q <= '0;
			sclk_q <= 1'b0;
		end else if (gen_tick) begin
			sdiv_q <= '0;
			sclk_q <= !sclk_q;
		end else begin
			sdiv_q <= sdiv_q + 1'b1;
		end
	end

	// Output word sequencer and ready indicator
	assign fifo_out_ready = (st_q == TX_LOAD) && (ld_cnt_q == MCLK_LAST);

	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			st_q           <= TX_IDLE;
			ld_cnt_q       <= '0;
			bit_cnt_q      <= '0;
			burst_q        <= '0;
			shreg_q        <= '0;
			word_ready_n_q <= 1'b1;
			chain_done_q   <= 1'b0;
			sdo_oe_q       <= 1'b0;
			rfs_out_q      <= 1'b0;
		end else if (clr_s) begin
			st_q           <= TX_IDLE; // R15
			ld_cnt_q       <= '0;
			bit_cnt_q      <= '0;
			burst_q        <= '0;
			word_ready_n_q <= 1'b1;
			chain_done_q   <= 1'b0;
			sdo_oe_q       <= 1'b0;
			rfs_out_q      <= 1'b0;
		end else begin
			unique case (st_q)
				TX_IDLE: begin
					if (fifo_out_valid && chain_s && !frame_on && !frame_act_q) begin // R5 R17
						st_q         <= TX_LOAD;
						ld_cnt_q     <= '0;
						burst_q      <= '0;
						chain_done_q <= 1'b0;
					end
				end
				TX_LOAD: begin
					word_ready_n_q <= 1'b1; // R3 R4
					if (ld_cnt_q != MCLK_LAST) begin
						ld_cnt_q <= ld_cnt_q + 1'b1;
					end else if (fifo_out_valid) begin
						shreg_q        <= fifo_out_data;
						st_q           <= TX_SHIFT;
						bit_cnt_q      <= '0;
						word_ready_n_q <= 1'b0; // R1
						sdo_oe_q       <= 1'b1;
						rfs_out_q      <= master_q;
					end
				end
				TX_SHIFT: begin
					if (tx_fall) begin
						shreg_q <= {shreg_q[WORD_W-2:0], 1'b0};
					end
					if (tx_rise) begin
						if (bit_cnt_q != WORD_LAST) begin
							bit_cnt_q <= bit_cnt_q + 1'b1;
						end else begin
							sdo_oe_q       <= 1'b0;
							rfs_out_q      <= 1'b0;
							word_ready_n_q <= 1'b1; // R2 R3
							if (burst_q == CHAN_LAST) begin
								st_q         <= TX_IDLE;
								chain_done_q <= 1'b1; // R17
							end else begin
								st_q     <= TX_LOAD;
								ld_cnt_q <= '0;
								burst_q  <= burst_q + 1'b1; // R19
							end
						end
					end
				end
			endcase
		end
	end

	// Control register writes inside the write frame
	always_ff @(posedge clk_sys_in or negedge rst_n_q) begin
		if (!rst_n_q) begin
			frame_act_q  <= 1'b0;
			ctrl_shift_q <= '0;
			ccnt_q       <= '0;
			ctrl_q       <= CTRL_RESET;
		end else if (clr_s) begin
			frame_act_q <= 1'b0;
			ccnt_q      <= '0;
		end else if (frame_act_q) begin
			if (!frame_on) begin
				frame_act_q <= 1'b0;
				if (ccnt_q == CTRL_FULL) begin
					ctrl_q <= ctrl_shift_q; // R5 R7
				end
			end else if (cap) begin
				ctrl_shift_q <= {ctrl_shift_q[CTRL_W-2:0], sdi_s}; // R5
				if (ccnt_q != CTRL_FULL) begin
					ccnt_q <= ccnt_q + 1'b1;
				end
			end
		end else if (frame_on && st_q == TX_IDLE) begin
			frame_act_q <= 1'b1;
			ccnt_q      <= '0;
		end
	end

	assign rx_frame_sync_out    = rfs_out_q;
	assign rx_frame_sync_oe_out = master_q; // R16
	assign sclk_out             = sclk_q;
	assign sclk_oe_out          = master_q; // R16
	assign serial_io_out        = shreg_q[WORD_W-1];
	assign serial_io_oe_out     = sdo_oe_q;
	assign word_ready_n_out     = word_ready_n_q;
	assign chain_done_out       = chain_done_q;
	assign gp_out_a_out         = ctrl_q[CTRL_GPA_BIT]; // R7
	assign gp_out_b_out         = ctrl_q[CTRL_GPB_BIT]; // R7
	assign cutoff_sel_out       = ctrl_q[CTRL_FC_LSB +: 3];

	localparam int SAMP_PERIOD = MCLK_DIV * MOD_DIV;

	AST_SAMPLE_RATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || filt_rst) // R8
		samp_en |-> ##SAMP_PERIOD samp_en) else $error("sample enable period wrong");
	AST_READY_FALL: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R1
		$fell(word_ready_n_q) |-> $past(st_q) == TX_LOAD && $past(ld_cnt_q) == MCLK_LAST
		&& st_q == TX_SHIFT) else $error("ready fell outside word load");
	AST_READY_LOW: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R1
		st_q == TX_SHIFT |-> !word_ready_n_q) else $error("ready high while shifting");
	AST_RELOAD_PULSE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R3
		(tx_rise && bit_cnt_q == WORD_LAST && burst_q != CHAN_LAST)
		|=> word_ready_n_q && st_q == TX_LOAD && ld_cnt_q == '0) else $error("no reload pulse");
	AST_BURST_DONE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R2
		(tx_rise && bit_cnt_q == WORD_LAST && burst_q == CHAN_LAST)
		|=> word_ready_n_q && chain_done_q && st_q == TX_IDLE) else $error("burst end wrong");
	AST_WORD_FIELDS: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R18
		(pack_busy_q && fifo_in_ready) |-> fifo_in_data[AUX_BIT] == aux_s
		&& fifo_in_data[ADDR_LSB +: 3] == addr_s) else $error("word fields wrong");
	AST_CHAN_ORDER: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R19
		(fifo_out_ready && fifo_out_valid) |=> shreg_q[CHAN_LSB +: 2] == burst_q)
		else $error("channel order broken");
	AST_GP_UPDATE: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R7
		(frame_act_q && !frame_on && ccnt_q == CTRL_FULL) |=> gp_out_a_out ==
		$past(ctrl_shift_q[CTRL_GPA_BIT]) && gp_out_b_out == $past(ctrl_shift_q[CTRL_GPB_BIT]))
		else $error("general outputs not updated");
	AST_NO_TX_IN_FRAME: assert property (@(posedge clk_sys_in) disable iff (!rst_n_q || clr_s) // R5
		frame_act_q |-> st_q == TX_IDLE && !serial_io_oe_out) else $error("tx during write frame");
endmodule

// *** qsdsp_host.sv ***
// Serial host model: reads output words and writes control frames
`timescale 1ns/1ps
module qsdsp_host (
	input  wire logic clk_in,
	input  wire logic sclk_in,
	input  wire logic data_in,
	input  wire logic ready_n_in,
	output logic      frame_n_out,
	output logic      data_out
);
	logic [31:0] sh_q;
	logic        sclk_q;
	logic        dl_q;
	logic        dv_q;
	logic        wr_q;
	int          nb_q;
	int          run_q;
	int          cyc_q;
	logic [31:0] rec_q[$];
	int          pulse_q[$];
	int          start_q[$];
	initial begin
		frame_n_out = 1'b1;
		data_out = 1'b0;
		wr_q = 1'b0;
		sclk_q = 1'b0;
		dv_q = 1'b0;
		nb_q = 0;
		run_q = 0;
		cyc_q = 0;
	end
	// Released data line toggles every cycle
	always @(negedge clk_in) begin
		if (!wr_q) begin
			data_out <= ~data_out;
		end
	end
	// Bits latched just before each rise, only while ready is low
	always @(posedge clk_in) begin
		cyc_q <= cyc_q + 1;
		sclk_q <= sclk_in;
		if (ready_n_in) begin
			run_q <= run_q + 1;
		end else begin
			if (run_q > 100) begin
				start_q.push_back(cyc_q);
			end else if (run_q > 0) begin
				pulse_q.push_back(run_q);
			end
			run_q <= 0;
		end
		if (!sclk_in) begin
			dl_q <= data_in;
			dv_q <= !ready_n_in;
		end else if (!sclk_q && dv_q) begin
			sh_q <= {sh_q[30:0], dl_q};
			nb_q <= (nb_q == 31) ? 0 : nb_q + 1;
			if (nb_q == 31) begin
				rec_q.push_back({sh_q[30:0], dl_q});
			end
		end
	end
	// Control write framed by the write frame, MSB first
	task automatic write_ctrl(input logic [7:0] v, input int n);
		wr_q = 1'b1;
		@(negedge clk_in);
		frame_n_out = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			data_out = v[i];
			@(posedge sclk_in);
			if (i > 0) begin
				@(negedge sclk_in);
			end
		end
		@(negedge clk_in);
		frame_n_out = 1'b1;
		wr_q = 1'b0;
	endtask
endmodule

// *** qsdsp_top_tb.sv ***
// Testbench for the quad sigma-delta serial port
`timescale 1ns/1ps
module qsdsp_top_tb;
	import qsdsp_pkg::*;
	logic        clk, nrst, rpulse, chain_en, aux, mode;
	logic [2:0]  addr, fc;
	logic [3:0]  mod;
	logic        rfs_o, rfs_oe, sclk_o, sclk_oe, sd_o, sd_oe, rdy_n, done, gpa, gpb;
	wire         frame_n, host_d;
	wire         sclk_w = sclk_oe ? sclk_o : 1'b0;
	wire         rfs_w = rfs_oe ? rfs_o : 1'b0;
	wire         sd_w = sd_oe ? sd_o : host_d;
	int          mismatches = 0;
	int          num_checks = 0;
	int          seed, t;
	logic        fell = 1'b0;
	logic [31:0] w;
	logic [7:0]  wv[3] = '{8'h0C, 8'h10, 8'h1F};
	logic [7:0]  we[3] = '{8'h0C, 8'h10, 8'h10};
	int          wn[3] = '{8, 8, 5};

	qsdsp_top qsdsp_top_i (.clk_sys_in(clk), .nrst_in(nrst), .reset_pulse_in(rpulse),
		.mode_slave_in(mode), .chain_enable_in(chain_en), .aux_flag_in(aux),
		.device_addr_pins_in(addr), .mod_bit_in(mod), .ctrl_write_frame_n_in(frame_n),
		.rx_frame_sync_in(rfs_w), .rx_frame_sync_out(rfs_o), .rx_frame_sync_oe_out(rfs_oe),
		.sclk_in(sclk_w), .sclk_out(sclk_o), .sclk_oe_out(sclk_oe), .serial_io_in(sd_w),
		.serial_io_out(sd_o), .serial_io_oe_out(sd_oe), .word_ready_n_out(rdy_n),
		.chain_done_out(done), .gp_out_a_out(gpa), .gp_out_b_out(gpb), .cutoff_sel_out(fc));
	qsdsp_host qsdsp_host_i (.clk_in(clk), .sclk_in(sclk_w), .data_in(sd_w),
		.ready_n_in(rdy_n), .frame_n_out(frame_n), .data_out(host_d));

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (exp !== got) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic end_of_test;
		if (mismatches == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		repeat (90000) @(posedge clk);
		mismatches++;
		end_of_test();
	end

	// Ready must not fall while the chain enable is low
	always @(negedge clk) begin
		if (nrst && !chain_en && rdy_n === 1'b0) begin
			fell = 1'b1;
		end
	end

	initial begin
		seed = 32'h9a8cd97f;
		nrst = 1'b0;
		rpulse = 1'b0;
		mode = 1'b0;
		chain_en = 1'b0;
		aux = 1'($random(seed));
		addr = 3'($random(seed));
		mod = 4'($random(seed));
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		repeat (6) @(negedge clk);
		chk("master", 32'h3, {30'h0, sclk_oe, rfs_oe});
		for (int i = 0; i < 3; i++) begin
			qsdsp_host_i.write_ctrl(wv[i], wn[i]);
			repeat (6) @(negedge clk);
			chk("ctrl", {24'h0, we[i]}, {27'h0, gpb, gpa, fc});
		end
		while ($time < 27000 * 20) begin
			@(negedge clk);
		end
		chk("gated", 32'h0, {31'h0, fell});
		chain_en = 1'b1;
		for (int b = 0; b < 3; b++) begin
			t = 0;
			while (qsdsp_host_i.rec_q.size() < 4 && t < 30000) begin
				@(negedge clk);
				t++;
			end
			for (int c = 0; c < 4; c++) begin
				w = qsdsp_host_i.rec_q.pop_front();
				chk("tail", {22'h0, 2'(c), addr, aux, 4'h0}, {22'h0, w[9:0]});
				chk("sign", {31'h0, ~mod[c]}, {31'h0, w[31]});
			end
			t = 0;
			while (done !== 1'b1 && t < 300) begin
				@(negedge clk);
				t++;
			end
			chk("done", 32'h1, {31'h0, done & rdy_n});
			aux = 1'($random(seed));
			addr = 3'($random(seed));
		end
		t = qsdsp_host_i.start_q[2] - qsdsp_host_i.start_q[1];
		chk("period", MCLK_DIV * MOD_DIV * (1 << DEC_BASE_LOG2), t);
		chk("reloads", 9, qsdsp_host_i.pulse_q.size());
		for (int i = 0; i < qsdsp_host_i.pulse_q.size(); i++) begin
			chk("reload", MCLK_DIV, qsdsp_host_i.pulse_q[i]);
		end
		rpulse = 1'b1;
		mode = 1'b1;
		repeat (10) @(negedge clk);
		chk("resync", 32'hC, {28'h0, gpb, rdy_n, sd_oe, done});
		chk("slave", 32'h0, {30'h0, sclk_oe, rfs_oe});
		rpulse = 1'b0;
		repeat (4) @(negedge clk);
		end_of_test();
	end
endmodule
